// ==== hw/ecc_dual_decoder.v ====
`timescale 1ns/1ps
`default_nettype none
`include "ecc2_defs.vh"

module ecc_dual_decoder
(
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output reg         pslverr,
	input  wire        mem_valid,
	input  wire [15:0] mem_data,
	input  wire [5:0]  mem_pchk,
	input  wire [5:0]  mem_schk,
	output wire [11:0] dec_addr,
	input  wire [7:0]  dec_data,
	output wire [15:0] corr_data,
	output wire        corr_done,
	output wire        corr_uncorr,
	output wire        busy
);

	localparam [2:0] S_IDLE   = 3'h0;
	localparam [2:0] S_EVAL   = 3'h1;
	localparam [2:0] S_LOOKUP = 3'h2;
	localparam [2:0] S_APPLY  = 3'h3;
	localparam [2:0] S_INJECT = 3'h4;
	localparam [2:0] S_FINISH = 3'h5;

	reg  [2:0]  state_reg;
	reg  [2:0]  state_next;
	reg  [15:0] data_reg;
	reg  [15:0] data_next;
	reg  [5:0]  pchk_reg;
	reg  [5:0]  schk_reg;
	reg  [5:0]  inj_reg;
	reg  [5:0]  inj_next;
	reg  [11:0] addr_reg;
	reg  [11:0] addr_next;
	reg  [7:0]  hold_reg;
	reg  [7:0]  hold_next;
	reg  [1:0]  pass_reg;
	reg  [1:0]  pass_next;
	reg  [15:0] result_reg;
	reg         uncorr_reg;
	reg         uncorr_next;
	reg         noerr_reg;
	reg         noerr_next;
	reg         done_reg;
	reg         finish_pulse_reg;
	reg         enable_reg;
	reg         start_reg;
	reg  [15:0] din_reg;
	reg  [5:0]  din_pchk_reg;
	reg  [5:0]  din_schk_reg;

	wire [5:0]  psyn;
	wire [5:0]  ssyn;
	wire [15:0] pcorr;
	wire        p_none;
	wire        p_data;
	wire        s_none;
	wire        s_data;
	wire        apb_wr;
	wire        apb_rd;
	wire        launch_hw;
	wire        launch_sw;

	////////////////////////////////////////////////////////////////
	// Two syndrome generators, each with its own check field
	ecc_syndrome_gen #(.COLS(`PRI_COLS)) u_primary
	(
		.data       (data_reg),
		.check      (pchk_reg),
		.inject     (inj_reg),
		.syndrome   (psyn),
		.corr_data  (pcorr),
		.no_err     (p_none),
		.check_err  (),
		.data_err   (p_data),
		.double_err ()
	);

	ecc_syndrome_gen #(.COLS(`SEC_COLS)) u_secondary
	(
		.data       (data_reg),
		.check      (schk_reg),
		.inject     (6'h00),
		.syndrome   (ssyn),
		.corr_data  (),
		.no_err     (s_none),
		.check_err  (),
		.data_err   (s_data),
		.double_err ()
	);

	////////////////////////////////////////////////////////////////
	// Correction sequencer
	assign launch_hw = mem_valid && enable_reg && (state_reg == S_IDLE);
	assign launch_sw = start_reg && (state_reg == S_IDLE) && !mem_valid;

	always @*
	begin
		state_next  = state_reg;
		data_next   = data_reg;
		inj_next    = inj_reg;
		addr_next   = addr_reg;
		hold_next   = hold_reg;
		pass_next   = pass_reg;
		uncorr_next = uncorr_reg;
		noerr_next  = noerr_reg;
		case (state_reg)
			S_IDLE:
			begin
				if (launch_hw || launch_sw)
				begin
					data_next   = launch_hw ? mem_data : din_reg;
					inj_next    = 6'h00;
					pass_next   = 2'h0;
					hold_next   = 8'h00;
					uncorr_next = 1'b0;
					noerr_next  = 1'b0;
					state_next  = S_EVAL;
				end
			end
			S_EVAL:
			begin
				if (p_none && s_none)
				begin
					noerr_next = (pass_reg == 2'h0);
					state_next = S_FINISH;
				end
				else if ((p_none && !s_data) || (s_none && !p_data))
				begin
					noerr_next = (pass_reg == 2'h0);
					state_next = S_FINISH;
				end
				else if (p_data && s_data)
				begin
					data_next  = pcorr;
					state_next = S_FINISH;
				end
				else
				begin
					addr_next  = {ssyn, psyn};
					state_next = S_LOOKUP;
				end
			end
			S_LOOKUP:
			begin
				hold_next  = dec_data;
				state_next = S_APPLY;
			end
			S_APPLY:
			begin
				if (hold_reg[`DEC_FLAGBYTE])
				begin
					if (hold_reg[`DEC_CLASS] && p_data)
						data_next = pcorr;
					else if (hold_reg[`DEC_CLASS])
						data_next = data_reg;
					else
						uncorr_next = 1'b1;
					state_next = S_FINISH;
				end
				else if (pass_reg == `MAX_PASSES)
				begin
					uncorr_next = 1'b1;
					state_next  = S_FINISH;
				end
				else
				begin
					inj_next   = hold_reg[5:0];
					pass_next  = pass_reg + 2'h1;
					state_next = S_INJECT;
				end
			end
			S_INJECT:
			begin
				inj_next = 6'h00;
				if (!p_data)
				begin
					uncorr_next = 1'b1;
					state_next  = S_FINISH;
				end
				else
				begin
					// Known error still in the word: evaluate it again
					data_next  = pcorr;
					state_next = S_EVAL;
				end
			end
			S_FINISH:
			begin
				state_next = S_IDLE;
			end
			default:
			begin
				state_next = S_IDLE;
			end
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg        <= S_IDLE;
			data_reg         <= 16'h0000;
			pchk_reg         <= 6'h00;
			schk_reg         <= 6'h00;
			inj_reg          <= 6'h00;
			addr_reg         <= 12'h000;
			hold_reg         <= 8'h00;
			pass_reg         <= 2'h0;
			uncorr_reg       <= 1'b0;
			noerr_reg        <= 1'b0;
			result_reg       <= 16'h0000;
			finish_pulse_reg <= 1'b0;
		end
		else
		begin
			state_reg        <= state_next;
			data_reg         <= data_next;
			inj_reg          <= inj_next;
			addr_reg         <= addr_next;
			hold_reg         <= hold_next;
			pass_reg         <= pass_next;
			uncorr_reg       <= uncorr_next;
			noerr_reg        <= noerr_next;
			finish_pulse_reg <= (state_reg == S_FINISH);
			if (launch_hw)
			begin
				pchk_reg <= mem_pchk;
				schk_reg <= mem_schk;
			end
			else if (launch_sw)
			begin
				pchk_reg <= din_pchk_reg;
				schk_reg <= din_schk_reg;
			end
			if (state_reg == S_FINISH)
				result_reg <= data_reg;
		end
	end

	assign dec_addr    = addr_reg;
	assign corr_data   = result_reg;
	assign corr_done   = finish_pulse_reg;
	assign corr_uncorr = uncorr_reg;
	assign busy        = (state_reg != S_IDLE);

	////////////////////////////////////////////////////////////////
	// APB slave, zero wait states
	assign pready = 1'b1;
	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && !pwrite;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			enable_reg   <= `CTRL_RESET;
			start_reg    <= 1'b0;
			din_reg      <= `DIN_RESET;
			din_pchk_reg <= 6'h00;
			din_schk_reg <= 6'h00;
			done_reg     <= 1'b0;
		end
		else
		begin
			if (launch_sw)
				start_reg <= 1'b0;
			if (apb_wr)
			begin
				if (paddr == `OFS_CTRL)
				begin
					enable_reg <= pwdata[`CTRL_ENABLE];
					if (pwdata[`CTRL_START])
						start_reg <= 1'b1;
				end
				else if (paddr == `OFS_DIN)
					din_reg <= pwdata[15:0];
				else if (paddr == `OFS_CHK)
				begin
					din_pchk_reg <= pwdata[5:0];
					din_schk_reg <= pwdata[13:8];
				end
			end
			// Completion wins over a clear in the same cycle
			if (finish_pulse_reg)
				done_reg <= 1'b1;
			else if (apb_wr && (paddr == `OFS_STATUS) && pwdata[`ST_DONE])
				done_reg <= 1'b0;
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else if (psel && !penable)
		begin
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
			if (paddr == `OFS_CTRL)
				prdata <= {30'h00000000, start_reg, enable_reg};
			else if (paddr == `OFS_DIN)
				prdata <= {16'h0000, din_reg};
			else if (paddr == `OFS_CHK)
				prdata <= {18'h00000, din_schk_reg, 2'h0, din_pchk_reg};
			else if (paddr == `OFS_STATUS)
			begin
				if (apb_rd)
					prdata <= {26'h0000000, pass_reg, noerr_reg, uncorr_reg,
						done_reg, busy};
			end
			else if (paddr == `OFS_RESULT)
				prdata <= {16'h0000, result_reg};
			else if (paddr == `OFS_HOLD)
				prdata <= {12'h000, hold_reg, addr_reg};
			else
				pslverr <= 1'b1;
		end
	end

endmodule // ecc_dual_decoder

`default_nettype wire

// ==== hw/ecc2_defs.vh ====
`ifndef ECC2_DEFS_VH
`define ECC2_DEFS_VH

// Register byte offsets
`define OFS_CTRL      12'h000
`define OFS_DIN       12'h004
`define OFS_CHK       12'h008
`define OFS_STATUS    12'h00C
`define OFS_RESULT    12'h010
`define OFS_HOLD      12'h014

// CTRL fields
`define CTRL_ENABLE   0
`define CTRL_START    1

// STATUS fields
`define ST_BUSY       0
`define ST_DONE       1
`define ST_UNCORR     2
`define ST_NOERR      3
`define ST_PASS_LO    4
`define ST_PASS_HI    5

// Reset values
`define CTRL_RESET    1'b1
`define DIN_RESET     16'h0000
`define CHK_RESET     12'h000

// Decoder byte fields
`define DEC_FLAGBYTE  7
`define DEC_CLASS     6
`define DEC_F_PCHK    0
`define DEC_F_SCHK    1
`define DEC_F_DATA    4
`define DEC_CNT_HI    5

// Largest number of injection passes
`define MAX_PASSES    2'h2

// Check matrix columns, column 15 first, column 0 last
`define PRI_COLS {6'h1F, 6'h2F, 6'h37, 6'h2C, 6'h13, 6'h0D, 6'h0B, 6'h3E, \
	6'h19, 6'h23, 6'h31, 6'h25, 6'h07, 6'h29, 6'h38, 6'h34}
`define SEC_COLS {6'h34, 6'h1F, 6'h2F, 6'h37, 6'h2C, 6'h13, 6'h0D, 6'h0B, \
	6'h3E, 6'h19, 6'h23, 6'h31, 6'h25, 6'h07, 6'h29, 6'h38}

`endif

// ==== hw/ecc_syndrome_gen.v ====
`timescale 1ns/1ps
`default_nettype none

module ecc_syndrome_gen
#(
	parameter [95:0] COLS = 96'h0
)
(
	input  wire [15:0] data,
	input  wire [5:0]  check,
	input  wire [5:0]  inject,
	output reg  [5:0]  syndrome,
	output reg  [15:0] corr_data,
	output wire        no_err,
	output wire        check_err,
	output wire        data_err,
	output wire        double_err
);

	integer i;
	integer j;
	wire    single_one;
	wire    odd_ones;

	////////////////////////////////////////////////////////////////
	// Syndrome: XOR of columns of every set bit, check and injection
	always @*
	begin
		syndrome = check ^ inject;
		for (i = 0; i < 16; i = i + 1)
			if (data[i])
				syndrome = syndrome ^ COLS[i*6 +: 6];
	end

	////////////////////////////////////////////////////////////////
	// Classification by count of ones
	assign odd_ones   = ^syndrome;
	assign single_one = (syndrome != 6'h00) && ((syndrome & (syndrome - 6'h01)) == 6'h00);
	assign no_err     = (syndrome == 6'h00);
	assign check_err  = single_one;
	assign data_err   = odd_ones && !single_one;
	assign double_err = !odd_ones && (syndrome != 6'h00);

	////////////////////////////////////////////////////////////////
	// Invert the bit whose column matches
	always @*
	begin
		corr_data = data;
		for (j = 0; j < 16; j = j + 1)
			if (data_err && (syndrome == COLS[j*6 +: 6]))
				corr_data[j] = ~data[j];
	end

endmodule // ecc_syndrome_gen

`default_nettype wire

// ==== test/ecc_dual_decoder_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module ecc_dual_decoder_props
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        busy,
	input wire logic [11:0] dec_addr,
	input wire logic [15:0] corr_data,
	input wire logic        corr_done,
	input wire logic        corr_uncorr
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
sequence launch_s;
	$rose(busy);
endsequence
sequence acc_s;
	psel && penable;
endsequence
ready_high_a: assert property (pready) else $error("pready low");
bad_addr_a: assert property (acc_s |-> pslverr == (paddr > 12'h014 || paddr[1:0] != 2'b00))
	else $error("pslverr mismatch");
err_zero_a: assert property (acc_s ##0 (!pwrite && pslverr) |-> prdata == 32'h0)
	else $error("error read not zero");
done_bound_a: assert property (launch_s |-> ##[2:40] corr_done) else $error("no done");
done_pulse_a: assert property (corr_done |=> !corr_done) else $error("done too long");
data_hold_a: assert property ($changed(corr_data) |-> corr_done) else $error("data moved");
unc_clear_a: assert property (launch_s |-> !corr_uncorr) else $error("uncorr kept");
dec_busy_a: assert property ($changed(dec_addr) |-> $past(busy)) else $error("addr idle");
done_busy_a: assert property (corr_done |-> $past(busy)) else $error("done idle");
endmodule // ecc_dual_decoder_props
bind ecc_dual_decoder ecc_dual_decoder_props u_props
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy),
	.dec_addr(dec_addr), .corr_data(corr_data), .corr_done(corr_done),
	.corr_uncorr(corr_uncorr)
);
`default_nettype wire

// ==== test/ecc_decoder_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ecc2_defs.vh"
module ecc_decoder_model
(
	input  wire logic [11:0] dec_addr,
	output var  logic [7:0]  dec_data
);
localparam logic [95:0] P = `PRI_COLS;
localparam logic [95:0] S = `SEC_COLS;
// Byte per 12-bit address: {secondary, primary}
always_comb
begin
	dec_data = 8'hB8;
	for (int a = 0; a < 16; a++)
	begin
		for (int c = 0; c < 6; c++)
			if (dec_addr == {S[a*6+:6] ^ (6'h01 << c), P[a*6+:6]})
				dec_data = 8'hD2;
		for (int b = a + 1; b < 16; b++)
			if (dec_addr == {S[a*6+:6] ^ S[b*6+:6], P[a*6+:6] ^ P[b*6+:6]})
				dec_data = {2'b00, P[a*6+:6]};
	end
end
endmodule // ecc_decoder_model
`default_nettype wire

// ==== test/dual_field_two_bit_ecc_decoder_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ecc2_defs.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
	$display("FAIL %0t %h %h", $time, a, b); end end
module dual_field_two_bit_ecc_decoder_tb;
localparam logic [95:0] P = `PRI_COLS;
localparam logic [95:0] S = `SEC_COLS;
logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mem_valid = 0;
logic [11:0] paddr = 0, dec_addr;
logic [31:0] pwdata = 0, prdata, rd;
logic [15:0] mem_data = 0, corr_data;
logic [5:0]  mem_pchk = 0, mem_schk = 0;
logic [7:0]  dec_data;
logic        pready, pslverr, corr_done, corr_uncorr, busy, er;
int          num_errors = 0, n_compared = 0, cycles = 0;
ecc_dual_decoder DUT
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.mem_valid(mem_valid), .mem_data(mem_data), .mem_pchk(mem_pchk), .mem_schk(mem_schk),
	.dec_addr(dec_addr), .dec_data(dec_data), .corr_data(corr_data),
	.corr_done(corr_done), .corr_uncorr(corr_uncorr), .busy(busy)
);
ecc_decoder_model u_dec
(
	.dec_addr(dec_addr),
	.dec_data(dec_data)
);
always #5 pclk = ~pclk;
always @(posedge pclk)
begin
	cycles++;
	if (cycles == 20000)
	begin
		num_errors++;
		finish_test();
	end
end
////////////////////////////////////////////////////////////////
function automatic logic [5:0] gen(input logic [95:0] m, input logic [15:0] d);
	gen = 6'h00;
	for (int i = 0; i < 16; i++)
		if (d[i])
			gen ^= m[i*6+:6];
endfunction
task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
	psel <= 1'b1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1'b1;
	do
		@(posedge pclk);
	while (pready !== 1'b1);
	rd = prdata;
	er = pslverr;
	psel <= 1'b0;
	penable <= 1'b0;
	@(posedge pclk);
endtask
// Launch one stored word with flipped bits and judge the result
task automatic run(input logic [15:0] d, f, input logic [5:0] pf, sf, input logic unc);
	int n;
	mem_valid <= 1'b1;
	mem_data <= d ^ f;
	mem_pchk <= gen(P, d) ^ pf;
	mem_schk <= gen(S, d) ^ sf;
	@(posedge pclk);
	mem_valid <= 1'b0;
	n = 0;
	do
	begin
		@(posedge pclk);
		n++;
	end
	while (corr_done !== 1'b1 && n < 50);
	`CHK({corr_done, busy}, 2'b10)
	`CHK(corr_uncorr, unc)
	if (!unc)
		`CHK(corr_data, d)
endtask
////////////////////////////////////////////////////////////////
task automatic t_regs();
	apb(1'b0, `OFS_CTRL, 32'h0);
	`CHK(rd[0], `CTRL_RESET)
	apb(1'b0, 12'h018, 32'h0);
	`CHK({er, rd}, {1'b1, 32'h0})
	apb(1'b1, `OFS_DIN, 32'h0000A5C3);
	apb(1'b0, `OFS_DIN, 32'h0);
	`CHK(rd, 32'h0000A5C3)
endtask
task automatic t_simple();
	run(16'h1234, 16'h0, 6'h00, 6'h00, 1'b0);
	apb(1'b0, `OFS_STATUS, 32'h0);
	`CHK(rd[`ST_NOERR:`ST_BUSY], 4'b1010)
	for (int i = 0; i < 16; i++)
		run(16'hBEEF, 16'h1 << i, 6'h00, 6'h00, 1'b0);
	for (int c = 0; c < 6; c++)
		run(16'h5A5A, 16'h0, 6'h01 << c, 6'h00, 1'b0);
	run(16'h5A5A, 16'h0, 6'h03, 6'h00, 1'b0);
	run(16'hC3C3, 16'h0, 6'h00, 6'h3F, 1'b0);
endtask
task automatic t_decoded();
	logic [15:0] f;
	for (int a = 0; a < 16; a++)
	begin
		f = (16'h1 << a) | (16'h1 << ((a + 5) % 16));
		run(16'h0F0F, f, 6'h0, 6'h0, 1'b0);
		`CHK(dec_addr, ({gen(S, f), gen(P, f)}))
	end
	apb(1'b0, `OFS_STATUS, 32'h0);
	`CHK(rd[`ST_PASS_HI:`ST_PASS_LO], 2'h1)
	for (int i = 0; i < 16; i++)
	begin
		f = 16'h1 << i;
		run(16'h9876, f, 6'h00, 6'h01 << (i % 6), 1'b0);
		`CHK(dec_addr, ({gen(S, f) ^ (6'h01 << (i % 6)), gen(P, f)}))
	end
	apb(1'b0, `OFS_HOLD, 32'h0);
	`CHK({rd[12 + `DEC_FLAGBYTE], rd[12 + `DEC_F_DATA], rd[12 + `DEC_F_SCHK], rd[12 + `DEC_F_PCHK]}, 4'b1110)
	run(16'h4321, 16'h0, 6'h03, 6'h05, 1'b1);
	apb(1'b0, `OFS_STATUS, 32'h0);
	`CHK(rd[`ST_UNCORR], 1'b1)
endtask
// Software launch, done clear and the enable gate
task automatic t_sw();
	int n;
	apb(1'b1, `OFS_DIN, {16'h0000, 16'h3C5A ^ 16'h0100});
	apb(1'b1, `OFS_CHK, {18'h00000, gen(S, 16'h3C5A), 2'h0, gen(P, 16'h3C5A)});
	apb(1'b1, `OFS_CTRL, 32'h00000003);
	n = 0;
	while (corr_done !== 1'b1 && n < 50)
	begin
		@(posedge pclk);
		n++;
	end
	`CHK({corr_done, corr_uncorr, corr_data}, {2'b10, 16'h3C5A})
	apb(1'b0, `OFS_RESULT, 32'h0);
	`CHK(rd, 32'h00003C5A)
	apb(1'b1, `OFS_STATUS, 32'h00000002);
	apb(1'b0, `OFS_STATUS, 32'h0);
	`CHK(rd[`ST_DONE], 1'b0)
	apb(1'b1, `OFS_CTRL, 32'h0);
	mem_valid <= 1'b1;
	mem_data <= 16'hFFFF;
	@(posedge pclk);
	mem_valid <= 1'b0;
	repeat (4) @(posedge pclk);
	`CHK({busy, corr_data}, {1'b0, 16'h3C5A})
	apb(1'b1, `OFS_CTRL, 32'h00000001);
endtask
////////////////////////////////////////////////////////////////
task automatic finish_test();
	$display("Compared %0d, mismatches %0d", n_compared, num_errors);
	if (num_errors == 0 && n_compared > 0)
		$display("No errors found");
	else
		$display("Errors were found");
	$finish;
endtask
initial
begin
	repeat (16) @(posedge pclk);
	presetn <= 1'b1;
	@(posedge pclk);
	t_regs();
	t_simple();
	t_decoded();
	t_sw();
	finish_test();
end
endmodule // dual_field_two_bit_ecc_decoder_tb
`default_nettype wire
